// file: design/nrp_map.vh
// offsets, field positions, reset values and timing counts of the protection bytes
`ifndef NRP_MAP_VH
`define NRP_MAP_VH
`define NRP_OFS_REG_GUARD     8'he0
`define NRP_OFS_CFG_GUARD     8'he1
`define NRP_OFS_EE_GUARD      8'he2
`define NRP_OFS_ERASE         8'he3
`define NRP_OFS_LOCK          8'he4
`define NRP_OFS_CHIP_MODE     8'hf6
`define NRP_RGRD_RD_LSB       0
`define NRP_RGRD_WR_LSB       2
`define NRP_WP_SIZE_LSB       0
`define NRP_WP_EN_BIT         2
`define NRP_ERS_PAGE_MSB      4
`define NRP_ERS_TRIG_BIT      7
`define NRP_CHIP_INH_BIT      4
`define NRP_CHIP_SEL_BIT      5
`define NRP_LOCK_BIT          0
`define NRP_RST_BYTE          8'h00
`define NRP_ERASED_BYTE       8'h00
`define NRP_ERASE_NS          1000
`define NRP_CLK_NS            20
`define NRP_ERASE_CYC         ((`NRP_ERASE_NS + `NRP_CLK_NS - 1) / `NRP_CLK_NS)
`endif

// file: design/nrp_mem.v
// byte memory with registered read data for the emulated eeprom
`timescale 1ns/1ns
module nrp_mem #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          clock,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire          re,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule // nrp_mem

// file: design/nrp_guard.v
// protection, lock and erase control bytes with gated access to registers, config and eeprom
`timescale 1ns/1ns
`include "nrp_map.vh"
module nrp_guard #(
    parameter [7:0] PART_LIMIT = 8'h80,
    parameter       ERASE_CYC  = `NRP_ERASE_CYC,
    parameter       PAGE_W     = 4
) (
    input  wire       clock,
    input  wire       sys_rst,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    output reg        reg_wr_ok,
    output reg        reg_rd_ok,
    input  wire       cfg_rd,
    input  wire       cfg_wr,
    output reg        cfg_rd_ok,
    output reg        cfg_wr_ok,
    input  wire       ee_wr,
    input  wire       ee_rd,
    input  wire [7:0] ee_addr,
    input  wire [7:0] ee_wdata,
    output reg  [7:0] ee_rdata,
    output reg        ee_ack,
    output reg        erase_busy,
    output reg        erase_full,
    output reg        erase_start,
    output reg  [4:0] erase_page
);
    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    reg  [1:0]  rd_guard_r;
    reg  [1:0]  wr_guard_r;
    reg  [1:0]  cfg_guard_r;
    reg  [1:0]  wp_size_r;
    reg         wp_en_r;
    reg  [4:0]  page_r;
    reg         chip_sel_r;
    reg         chip_inh_r;
    reg         lock_r;
    reg         state_r;
    reg  [15:0] cnt_r;
    reg  [7:0]  rdata_nxt;
    reg         mem_sel_r;
    wire [7:0]  mem_rdata;
    wire        ee_wr_ok;
    wire        rd_allow;
    wire        wr_allow;
    wire        guard_byte;
    wire        mem_we;
    wire        mem_re;
    reg  [8:0]  wipe_left_r;
    reg  [7:0]  wipe_addr_r;
    wire        ers_top;
    wire        erase_ok;
    wire        wipe_we;
    wire        mem_wen;
    wire [7:0]  mem_waddr;
    wire [7:0]  mem_wdata;

    // true when the address is refused under the given guard code
    function blocked;
        input [1:0] code;
        input [7:0] addr;
        begin
            case (code)
                2'h1:    blocked = (addr < PART_LIMIT);
                2'h2:    blocked = 1'b1;
                default: blocked = 1'b0;
            endcase
        end
    endfunction

    // true when an eeprom address falls in the protected upper span
    function ee_protected;
        input [1:0] size;
        input [7:0] addr;
        begin
            case (size)
                2'h0:    ee_protected = (addr[7:6] == 2'h3);
                2'h1:    ee_protected = addr[7];
                2'h2:    ee_protected = (addr[7:6] != 2'h0);
                default: ee_protected = 1'b1;
            endcase
        end
    endfunction

    // true when a trigger may start an erase; a guarded config half also refuses full erase
    function erase_allowed;
        input sel;
        input inh;
        input top;
        input cfg_wp;
        begin
            if (sel) begin
                erase_allowed = ~inh & ~cfg_wp;
            end else begin
                erase_allowed = top | ~cfg_wp;
            end
        end
    endfunction

    // bytes of the emulated eeprom cleared by an erase
    function [8:0] wipe_span;
        input full;
        input top;
        begin
            if (full) begin
                wipe_span = 9'h100;
            end else if (top) begin
                wipe_span = 9'h100 >> PAGE_W;
            end else begin
                wipe_span = 9'h000;
            end
        end
    endfunction

    assign rd_allow   = ~blocked(rd_guard_r, reg_addr);
    assign wr_allow   = ~blocked(wr_guard_r, reg_addr);
    assign guard_byte = (reg_addr == `NRP_OFS_REG_GUARD) | (reg_addr == `NRP_OFS_CFG_GUARD) |
                        (reg_addr == `NRP_OFS_EE_GUARD);
    assign ee_wr_ok   = ~(wp_en_r & ee_protected(wp_size_r, ee_addr));
    assign mem_we     = ee_wr & ee_wr_ok & (state_r == ST_IDLE);
    assign mem_re     = ee_rd & (state_r == ST_IDLE);
    assign ers_top    = reg_wdata[`NRP_ERS_PAGE_MSB];
    assign erase_ok   = erase_allowed(chip_sel_r, chip_inh_r, ers_top, cfg_guard_r[1]);
    assign wipe_we    = (state_r == ST_BUSY) & (wipe_left_r != 9'h000);
    assign mem_wen    = mem_we | wipe_we;
    assign mem_waddr  = wipe_we ? wipe_addr_r : ee_addr;
    assign mem_wdata  = wipe_we ? `NRP_ERASED_BYTE : ee_wdata;

    nrp_mem #(
        .AW (8),
        .DW (8)
    ) u_mem (
        .clock (clock),
        .we    (mem_wen),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .re    (mem_re),
        .raddr (ee_addr),
        .rdata (mem_rdata)
    );

    always @* begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            `NRP_OFS_REG_GUARD: rdata_nxt = {4'h0, wr_guard_r, rd_guard_r};
            `NRP_OFS_CFG_GUARD: rdata_nxt = {6'h00, cfg_guard_r};
            `NRP_OFS_EE_GUARD:  rdata_nxt = {5'h00, wp_en_r, wp_size_r};
            `NRP_OFS_ERASE:     rdata_nxt = {state_r, 2'h0, page_r};
            `NRP_OFS_LOCK:      rdata_nxt = {7'h00, lock_r};
            `NRP_OFS_CHIP_MODE: rdata_nxt = {2'h0, chip_sel_r, chip_inh_r, 4'h0};
            default:            rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            rd_guard_r  <= 2'h0;
            wr_guard_r  <= 2'h0;
            cfg_guard_r <= 2'h0;
            wp_size_r   <= 2'h0;
            wp_en_r     <= 1'b0;
            page_r      <= 5'h00;
            chip_sel_r  <= 1'b0;
            chip_inh_r  <= 1'b0;
            lock_r      <= 1'b0;
            state_r     <= ST_IDLE;
            cnt_r       <= 16'h0000;
            reg_rdata   <= `NRP_RST_BYTE;
            reg_wr_ok   <= 1'b0;
            reg_rd_ok   <= 1'b0;
            cfg_rd_ok   <= 1'b0;
            cfg_wr_ok   <= 1'b0;
            ee_ack      <= 1'b0;
            mem_sel_r   <= 1'b0;
            ee_rdata    <= 8'h00;
            erase_busy  <= 1'b0;
            erase_full  <= 1'b0;
            erase_start <= 1'b0;
            erase_page  <= 5'h00;
            wipe_left_r <= 9'h000;
            wipe_addr_r <= 8'h00;
        end else begin
            reg_rd_ok   <= reg_rd & rd_allow;
            reg_rdata   <= (reg_rd & rd_allow) ? rdata_nxt : 8'h00;
            reg_wr_ok   <= reg_wr & wr_allow & ~(lock_r & guard_byte);
            cfg_rd_ok   <= cfg_rd & ~cfg_guard_r[0] & (state_r == ST_IDLE);
            cfg_wr_ok   <= cfg_wr & ~cfg_guard_r[1] & (state_r == ST_IDLE);
            ee_ack      <= mem_we | mem_re;
            mem_sel_r   <= mem_re;
            if (mem_sel_r) begin
                ee_rdata <= mem_rdata;
            end
            erase_start <= 1'b0;
            if (reg_wr & wr_allow) begin
                if (~lock_r) begin
                    if (reg_addr == `NRP_OFS_REG_GUARD) begin
                        if (reg_wdata[1:0] != 2'h3) begin
                            rd_guard_r <= reg_wdata[1:0];
                        end
                        if (reg_wdata[3:2] != 2'h3) begin
                            wr_guard_r <= reg_wdata[3:2];
                        end
                    end
                    if (reg_addr == `NRP_OFS_CFG_GUARD) begin
                        cfg_guard_r <= reg_wdata[1:0];
                    end
                    if (reg_addr == `NRP_OFS_EE_GUARD) begin
                        wp_size_r <= reg_wdata[1:0];
                        wp_en_r   <= reg_wdata[`NRP_WP_EN_BIT];
                    end
                end
                if (reg_addr == `NRP_OFS_LOCK) begin
                    lock_r <= lock_r | reg_wdata[`NRP_LOCK_BIT];
                end
                if (reg_addr == `NRP_OFS_CHIP_MODE) begin
                    chip_sel_r <= reg_wdata[`NRP_CHIP_SEL_BIT];
                    chip_inh_r <= reg_wdata[`NRP_CHIP_INH_BIT];
                end
                if (reg_addr == `NRP_OFS_ERASE && state_r == ST_IDLE) begin
                    page_r <= reg_wdata[4:0];
                end
            end
            case (state_r)
                ST_IDLE: begin
                    if (reg_wr & wr_allow & (reg_addr == `NRP_OFS_ERASE) &
                        reg_wdata[`NRP_ERS_TRIG_BIT]) begin
                        // full erase only with select set and inhibit clear
                        if (erase_ok) begin
                            state_r     <= ST_BUSY;
                            cnt_r       <= 16'h0000;
                            erase_busy  <= 1'b1;
                            erase_start <= 1'b1;
                            erase_full  <= chip_sel_r;
                            erase_page  <= reg_wdata[4:0];
                            wipe_left_r <= wipe_span(chip_sel_r, ers_top);
                            wipe_addr_r <= chip_sel_r ? 8'h00 :
                                           {reg_wdata[PAGE_W-1:0], {(8-PAGE_W){1'b0}}};
                        end
                    end
                end
                ST_BUSY: begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (wipe_we) begin
                        wipe_left_r <= wipe_left_r - 9'h001;
                        wipe_addr_r <= wipe_addr_r + 8'h01;
                    end
                    // busy covers the longer of the erase time and the eeprom wipe
                    if ((cnt_r >= ERASE_CYC[15:0] - 16'h0001) &&
                        (wipe_left_r <= 9'h001)) begin
                        state_r    <= ST_IDLE;
                        erase_busy <= 1'b0;
                        erase_full <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // nrp_guard

// file: test/nrp_guard_assertions.sv
// checker on the protection, lock and erase ports
`timescale 1ns/1ns
module nrp_guard_chk #(
    parameter int ERASE_CYC = 50,
    parameter int PAGE_W    = 4
) (
    input wire       clock,
    input wire       sys_rst,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire       reg_wr_ok,
    input wire       reg_rd_ok,
    input wire       cfg_rd,
    input wire       cfg_rd_ok,
    input wire       ee_wr,
    input wire       ee_rd,
    input wire       ee_ack,
    input wire       erase_busy,
    input wire       erase_full,
    input wire       erase_start,
    input wire [4:0] erase_page
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    reg        pend_r;
    reg        lock_r;
    reg [15:0] cnt_r;
    reg [15:0] len_r;
    wire [15:0] span = erase_full ? 16'h0100 : (erase_page[4] ? (16'h0100 >> PAGE_W) : 16'h0000);
    always @(posedge clock) begin
        if (erase_start) len_r <= (span > 16'(ERASE_CYC)) ? span : 16'(ERASE_CYC);
        pend_r <= reg_wr && reg_addr == 8'he4 && reg_wdata[0];
        lock_r <= !sys_rst && (lock_r || (pend_r && reg_wr_ok));
        cnt_r  <= (sys_rst || !erase_busy) ? 16'h0000 : cnt_r + 16'h0001;
    end
    sequence s_trig;
        reg_wr && reg_addr == 8'he3 && reg_wdata[7];
    endsequence
    sequence s_run;
        erase_start ##1 (erase_busy && !erase_start);
    endsequence
    chk_rd_answer: assert property (reg_rd_ok |-> $past(reg_rd))
        else $error("read answer without request");
    chk_rd_refused: assert property (!reg_rd_ok |-> reg_rdata == 8'h00)
        else $error("read data shown while refused");
    chk_wr_answer: assert property (reg_wr_ok |-> $past(reg_wr))
        else $error("write accept without request");
    chk_lock_refuse: assert property (lock_r && reg_wr && reg_addr >= 8'he0
        && reg_addr <= 8'he2 |=> !reg_wr_ok) else $error("locked guard write accepted");
    chk_cfg_answer: assert property (cfg_rd_ok |-> $past(cfg_rd))
        else $error("config grant without request");
    chk_ee_answer: assert property (ee_ack |-> $past(ee_wr || ee_rd))
        else $error("eeprom ack without request");
    chk_start_cause: assert property (erase_start |->
        $past(reg_wr && reg_addr == 8'he3 && reg_wdata[7]))
        else $error("erase start without trigger");
    chk_start_pulse: assert property (erase_start |-> s_run)
        else $error("erase start not a pulse into busy");
    chk_start_page: assert property (s_trig ##1 erase_start |->
        erase_busy && erase_page == $past(reg_wdata[4:0]))
        else $error("erase page differs from trigger");
    chk_busy_len: assert property ($fell(erase_busy) |-> cnt_r == len_r)
        else $error("erase busy length wrong");
    chk_full_busy: assert property (erase_full |-> erase_busy)
        else $error("full erase flag outside erase");
endmodule // nrp_guard_chk
bind nrp_guard nrp_guard_chk #(.ERASE_CYC(ERASE_CYC), .PAGE_W(PAGE_W)) u_chk (.clock(clock),
    .sys_rst(sys_rst), .erase_page(erase_page),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_wr_ok(reg_wr_ok), .reg_rd_ok(reg_rd_ok), .cfg_rd(cfg_rd),
    .cfg_rd_ok(cfg_rd_ok), .ee_wr(ee_wr), .ee_rd(ee_rd), .ee_ack(ee_ack),
    .erase_busy(erase_busy), .erase_full(erase_full), .erase_start(erase_start));

// file: test/nrp_host.sv
// host model issuing single register, config and eeprom requests
`timescale 1ns/1ns
module nrp_host (
    input  wire       clock,
    output reg  [5:0] strb,
    output reg  [7:0] addr,
    output reg  [7:0] wdat
);
    initial begin
        strb = 6'h00;
        addr = 8'h00;
        wdat = 8'h00;
    end
    // one request at a time, finished before the next; idle lines scrambled
    task req(input [5:0] s, input [7:0] a, input [7:0] d);
        begin
            @(posedge clock);
            strb <= s;
            addr <= a;
            wdat <= d;
            @(posedge clock);
            strb <= 6'h00;
            addr <= ~a;
            wdat <= ~d;
            #1;
        end
    endtask
endmodule // nrp_host

// file: test/nrp_guard_tb.sv
// self-checking bench for the protection, lock and erase block
`timescale 1ns/1ns
`include "nrp_map.vh"
`define CHK(nm, e, s) begin n_checks = n_checks + 1; if ((s) !== (e)) begin \
    fails = fails + 1; $display("unexpected %s exp %h got %h", nm, e, s); end end
module nrp_guard_tb;
    reg         clock = 1'b0;
    reg         sys_rst = 1'b1;
    wire [5:0]  strb;
    wire [7:0]  addr, wdat, rdat, erd;
    wire        wok, rok, crok, cwok, ack, busy, full, start;
    wire [4:0]  page;
    integer     fails = 0, n_checks = 0, i, j;
    reg  [15:0] rnd = 16'hb0e1;
    reg  [7:0]  a;
    nrp_guard #(.PART_LIMIT(8'h80), .ERASE_CYC(4)) DUT (.clock(clock), .sys_rst(sys_rst),
        .reg_wr(strb[0]), .reg_rd(strb[1]), .reg_addr(addr), .reg_wdata(wdat),
        .reg_rdata(rdat), .reg_wr_ok(wok), .reg_rd_ok(rok), .cfg_rd(strb[2]),
        .cfg_wr(strb[3]), .cfg_rd_ok(crok), .cfg_wr_ok(cwok), .ee_wr(strb[4]),
        .ee_rd(strb[5]), .ee_addr(addr), .ee_wdata(wdat), .ee_rdata(erd), .ee_ack(ack),
        .erase_busy(busy), .erase_full(full), .erase_start(start), .erase_page(page));
    nrp_host host (.clock(clock), .strb(strb), .addr(addr), .wdat(wdat));
    function [7:0] bnd(input [1:0] s);
        bnd = 8'hc0 - {s, 6'h00};
    endfunction
    function [15:0] lfsr(input [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task wr(input [7:0] ad, input [7:0] d, input ok);
        begin
            host.req(6'h01, ad, d);
            `CHK("reg_wr_ok", ok, wok)
        end
    endtask
    task rd(input [7:0] ad, input [7:0] d, input ok);
        begin
            host.req(6'h02, ad, 8'h00);
            `CHK("reg_rd_ok", ok, rok)
            `CHK("reg_rdata", d, rdat)
        end
    endtask
    task wt(input v, input integer n);
        begin
            for (j = 0; j < n && busy !== v; j = j + 1)
                @(posedge clock) #1;
        end
    endtask
    task er(input [7:0] d, input run, input fl);
        begin
            host.req(6'h01, 8'he3, d);
            `CHK("erase_start", run, start)
            wt(1'b1, 3);
            `CHK("erase_busy", run, busy)
            if (run) begin
                `CHK("erase_full", fl, full)
                `CHK("erase_page", d[4:0], page)
                wt(1'b0, 300);
                `CHK("erase_end", 1'b0, busy)
                if (busy !== 1'b0) close_out;
            end
        end
    endtask
    task eer(input [7:0] ad, input [7:0] d);
        begin
            host.req(6'h20, ad, 8'h00);
            `CHK("ee_ack", 1'b1, ack)
            @(posedge clock) #1;
            `CHK("ee_rdata", d, erd)
        end
    endtask
    initial begin
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        for (i = 0; i < 5; i = i + 1) rd(8'he0 + i[7:0], 8'h00, 1'b1);
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'he2, {5'h00, i[2:0]}, 1'b1);
            for (j = 0; j < 6; j = j + 1) begin
                rnd = lfsr(rnd);
                a = (j < 2) ? bnd(i[1:0]) - j[7:0] : rnd[7:0];
                host.req(6'h10, a, rnd[15:8]);
                `CHK("ee_ack", !(i[2] && a >= bnd(i[1:0])), ack)
            end
        end
        wr(8'he2, 8'h03, 1'b1);
        host.req(6'h10, a, rnd[15:8]);
        `CHK("ee_ack", 1'b1, ack)
        eer(a, rnd[15:8]);
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'he1, i[7:0], 1'b1);
            host.req(6'h04, 8'h00, 8'h00);
            `CHK("cfg_rd_ok", !i[0], crok)
            host.req(6'h08, 8'h00, 8'h00);
            `CHK("cfg_wr_ok", !i[1], cwok)
        end
        er(8'h85, 1'b0, 1'b0);
        er(8'h90 | {4'h0, a[7:4]}, 1'b1, 1'b0);
        eer(a, `NRP_ERASED_BYTE);
        wr(8'he1, 8'h00, 1'b1);
        er(8'h85, 1'b1, 1'b0);
        wr(8'hf6, 8'h20, 1'b1);
        wr(8'he1, 8'h02, 1'b1);
        er(8'h80, 1'b0, 1'b0);
        wr(8'he1, 8'h00, 1'b1);
        er(8'h80, 1'b1, 1'b1);
        wr(8'hf6, 8'h30, 1'b1);
        er(8'h80, 1'b0, 1'b0);
        wr(8'he0, 8'h01, 1'b1);
        rd(8'h7f, 8'h00, 1'b0);
        wr(8'he0, 8'h03, 1'b1);
        rd(8'he0, 8'h01, 1'b1);
        wr(8'he0, 8'h02, 1'b1);
        rd(8'he0, 8'h00, 1'b0);
        wr(8'he0, 8'h04, 1'b1);
        wr(8'h10, 8'h00, 1'b0);
        wr(8'he0, 8'h08, 1'b1);
        wr(8'he0, 8'h00, 1'b0);
        @(posedge clock) sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd(8'he0, 8'h00, 1'b1);
        wr(8'he4, 8'h01, 1'b1);
        wr(8'he2, 8'h04, 1'b0);
        wr(8'he0, 8'h02, 1'b0);
        rd(8'he2, 8'h00, 1'b1);
        close_out;
    end
endmodule // nrp_guard_tb
